// [rtl/hltc_pkg.sv]
package hltc_pkg;

    // ********************************************************************
    // Register map (byte addresses, one aligned word each)
    // ********************************************************************
    localparam logic [11:0] HLTC_OFS_CLOCK_SELECT = 12'h000;
    localparam logic [11:0] HLTC_OFS_CONTROL      = 12'h004;
    localparam logic [11:0] HLTC_OFS_HW_LIMIT     = 12'h008;
    localparam logic [11:0] HLTC_OFS_EXT_RESET    = 12'h00c;
    localparam logic [11:0] HLTC_OFS_COUNT        = 12'h010;
    localparam logic [11:0] HLTC_OFS_PERIOD       = 12'h014;

    // ********************************************************************
    // Field positions and reset values
    // ********************************************************************
    localparam int          HLTC_POS_RUN        = 7;
    localparam int          HLTC_POS_PRESCALER_SYNC_ENABLE      = 7;
    localparam int          HLTC_POS_POLARITY   = 6;
    localparam int          HLTC_POS_RUN_SYNC   = 5;
    localparam logic [7:0]  HLTC_RST_REG        = 8'h00;
    localparam logic [7:0]  HLTC_RST_PERIOD     = 8'hff;
    localparam logic [4:0]  HLTC_MODE_ONE_SHOT  = 5'h08;
    localparam logic [3:0]  HLTC_CS_FIRST_RSVD  = 4'hc;
    localparam int          HLTC_NUM_SOURCES    = 12;
    localparam int          HLTC_RUN_SYNC_DEPTH = 2;

    // Control register view
    typedef struct packed {
        logic       run;
        logic [2:0] prescale_select;
        logic [3:0] postscale_select;
    } hltc_control_t;

    // Hardware limit register view
    typedef struct packed {
        logic       prescaler_sync_enable;
        logic       input_clock_polarity;
        logic       run_bit_sync_enable;
        logic [4:0] mode;
    } hltc_hw_limit_t;

    // Clock source codes
    typedef enum logic [3:0] {
        HLTC_CS_INSTR      = 4'h0,
        HLTC_CS_SYSTEM     = 4'h1,
        HLTC_CS_HFINT      = 4'h2,
        HLTC_CS_LFINT      = 4'h3,
        HLTC_CS_ZERO_CROSS = 4'h4,
        HLTC_CS_MFINT      = 4'h5,
        HLTC_CS_PIN        = 4'h6,
        HLTC_CS_LC1        = 4'h7,
        HLTC_CS_LC4        = 4'ha,
        HLTC_CS_ANGULAR    = 4'hb
    } hltc_clock_src_t;

    // Run control states
    typedef enum logic [2:0] {
        HLTC_ST_IDLE  = 3'b001,
        HLTC_ST_ARM   = 3'b010,
        HLTC_ST_COUNT = 3'b100
    } hltc_state_t;

endpackage

// [rtl/hltc_timer.sv]
// Local design decisions: the placing of the registers and register access over APB.
module hltc_timer
    import hltc_pkg::*;
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [HLTC_NUM_SOURCES-1:0] clock_sources,
    input  wire logic [15:0]                 ext_reset_sources,
    input  wire logic                        sleep_mode,
    output logic                             ext_reset_active,
    output logic                             postscaled_out,
    output logic [4:0]                       mode_out
);

    // ********************************************************************
    // Register storage
    // ********************************************************************
    logic [3:0]     clock_select_reg;
    hltc_control_t  control_reg;
    hltc_hw_limit_t hw_limit_reg;
    logic [3:0]     ext_reset_select_reg;
    logic [7:0]     period_value_reg;
    logic [7:0]     count_value_reg;
    logic [7:0]     count_shadow_reg;
    logic           hw_clear_run;
    logic           wr_en;
    logic           rd_en;
    logic           addr_ok;

    // APB decode: zero-wait, writes need byte lane 0
    assign wr_en   = psel & penable & pwrite & pstrb[0];
    assign rd_en   = psel & ~pwrite;
    assign addr_ok = (paddr == HLTC_OFS_CLOCK_SELECT) | (paddr == HLTC_OFS_CONTROL) |
                     (paddr == HLTC_OFS_HW_LIMIT) | (paddr == HLTC_OFS_EXT_RESET) |
                     (paddr == HLTC_OFS_COUNT) | (paddr == HLTC_OFS_PERIOD);

    // Software writable configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_select_reg     <= 4'h0;
            hw_limit_reg         <= HLTC_RST_REG;
            ext_reset_select_reg <= 4'h0;
            period_value_reg     <= HLTC_RST_PERIOD;
        end else if (wr_en) begin
            case (paddr)
                HLTC_OFS_CLOCK_SELECT: clock_select_reg     <= pwdata[3:0];
                HLTC_OFS_HW_LIMIT:     hw_limit_reg         <= pwdata[7:0];
                HLTC_OFS_EXT_RESET:    ext_reset_select_reg <= pwdata[3:0];
                HLTC_OFS_PERIOD:       period_value_reg     <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Control register; hardware clear of run wins only when the control register is not written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg <= HLTC_RST_REG;
        end else if (wr_en && paddr == HLTC_OFS_CONTROL) begin
            control_reg <= pwdata[7:0];
        end else if (hw_clear_run) begin
            control_reg.run <= 1'b0;
        end
    end

    // Read mux, unmapped reads zero with error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            prdata  <= 32'h0000_0000;
            if (rd_en && !penable) begin
                case (paddr)
                    HLTC_OFS_CLOCK_SELECT: prdata <= {28'h0, clock_select_reg};
                    HLTC_OFS_CONTROL:      prdata <= {24'h0, control_reg};
                    HLTC_OFS_HW_LIMIT:     prdata <= {24'h0, hw_limit_reg};
                    HLTC_OFS_EXT_RESET:    prdata <= {28'h0, ext_reset_select_reg};
                    HLTC_OFS_COUNT:        prdata <= {24'h0, count_shadow_reg};
                    HLTC_OFS_PERIOD:       prdata <= {24'h0, period_value_reg};
                    default:               prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ********************************************************************
    // Input clock selection and edge detection
    // ********************************************************************
    logic [HLTC_NUM_SOURCES-1:0] src_s1;
    logic [HLTC_NUM_SOURCES-1:0] src_s2;
    logic [HLTC_NUM_SOURCES-1:0] src_s3;
    logic [15:0]                 ers_s1;
    logic [15:0]                 ers_s2;
    logic [15:0]                 ers_s3;
    logic                        sel_level;
    logic                        sel_prev;
    logic                        clk_edge;
    logic                        instr_phase_reg;
    logic [1:0]                  instr_div_reg;

    // Three-stage synchronisers for every external clock source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_s1 <= '0;
            src_s2 <= '0;
            src_s3 <= '0;
            ers_s1 <= '0;
            ers_s2 <= '0;
            ers_s3 <= '0;
        end else begin
            src_s1 <= clock_sources;
            src_s2 <= src_s1;
            src_s3 <= src_s2;
            ers_s1 <= ext_reset_sources;
            ers_s2 <= ers_s1;
            ers_s3 <= ers_s2;
        end
    end

    // Instruction clock: one pulse every four system clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_div_reg   <= 2'h0;
            instr_phase_reg <= 1'b0;
        end else begin
            instr_div_reg   <= instr_div_reg + 2'h1;
            instr_phase_reg <= (instr_div_reg == 2'h3);
        end
    end

    // Source mux; a change counts when stages two and three differ
    always_comb begin
        sel_level = 1'b0;
        sel_prev  = 1'b0;
        if (clock_select_reg < HLTC_CS_FIRST_RSVD) begin
            sel_level = src_s2[clock_select_reg];
            sel_prev  = src_s3[clock_select_reg];
        end
    end

    // Edge chosen by polarity; instruction and system clocks are internal
    always_comb begin
        case (clock_select_reg)
            HLTC_CS_INSTR:  clk_edge = instr_phase_reg;
            HLTC_CS_SYSTEM: clk_edge = 1'b1;
            default: begin
                if (hw_limit_reg.input_clock_polarity) begin
                    clk_edge = sel_prev & ~sel_level;
                end else begin
                    clk_edge = ~sel_prev & sel_level;
                end
            end
        endcase
    end

    // ********************************************************************
    // Prescaler and run control
    // ********************************************************************
    logic [6:0]  presc_cnt_reg;
    logic        presc_tick;
    logic        tick;
    logic        presc_hold_reg;
    logic [HLTC_RUN_SYNC_DEPTH-1:0] run_pipe_reg;
    logic        run_eff;
    hltc_state_t state_reg;

    // Divide by two to the prescale code
    assign presc_tick = clk_edge &&
        ((presc_cnt_reg & ((7'h01 << control_reg.prescale_select) - 7'h01)) ==
         ((7'h01 << control_reg.prescale_select) - 7'h01));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_cnt_reg <= 7'h00;
        end else if (!control_reg.run) begin
            presc_cnt_reg <= 7'h00;
        end else if (clk_edge) begin
            presc_cnt_reg <= presc_cnt_reg + 7'h01;
        end
    end

    // Synchronised prescaler output waits for an instruction phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_hold_reg <= 1'b0;
        end else if (!control_reg.run || !hw_limit_reg.prescaler_sync_enable) begin
            presc_hold_reg <= 1'b0;
        end else if (presc_tick) begin
            presc_hold_reg <= 1'b1;
        end else if (instr_phase_reg) begin
            presc_hold_reg <= 1'b0;
        end
    end

    assign tick = hw_limit_reg.prescaler_sync_enable ?
                  ((presc_hold_reg | presc_tick) & instr_phase_reg & ~sleep_mode)
                  : presc_tick;

    // Run bit delayed by input clocks when run sync is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_pipe_reg <= '0;
        end else if (!control_reg.run) begin
            run_pipe_reg <= '0;
        end else if (clk_edge) begin
            run_pipe_reg <= {run_pipe_reg[HLTC_RUN_SYNC_DEPTH-2:0], 1'b1};
        end
    end

    // Stopping is never delayed, so no count slips in after run clears
    assign run_eff = control_reg.run &&
                     (!hw_limit_reg.run_bit_sync_enable ||
                      run_pipe_reg[HLTC_RUN_SYNC_DEPTH-1]);

    // Run state tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= HLTC_ST_IDLE;
        end else begin
            case (state_reg)
                HLTC_ST_IDLE:  state_reg <= control_reg.run ? HLTC_ST_ARM : HLTC_ST_IDLE;
                HLTC_ST_ARM:   state_reg <= !control_reg.run ? HLTC_ST_IDLE :
                                            run_eff ? HLTC_ST_COUNT : HLTC_ST_ARM;
                HLTC_ST_COUNT: state_reg <= control_reg.run ? HLTC_ST_COUNT : HLTC_ST_IDLE;
                default:       state_reg <= HLTC_ST_IDLE;
            endcase
        end
    end

    // ********************************************************************
    // Counter, postscaler, outputs
    // ********************************************************************
    logic       match;
    logic       count_en;
    logic [3:0] post_cnt_reg;

    // Counting needs the run state, the effective run bit and a tick
    assign count_en     = (state_reg == HLTC_ST_COUNT) && run_eff && tick;
    assign match        = (count_value_reg == period_value_reg);
    assign hw_clear_run = count_en && match &&
                          (hw_limit_reg.mode == HLTC_MODE_ONE_SHOT);

    // Count advances on ticks, cleared on period match, held when stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_reg <= 8'h00;
        end else if (count_en) begin
            if (match) begin
                count_value_reg <= 8'h00;
            end else begin
                count_value_reg <= count_value_reg + 8'h01;
            end
        end
    end

    // Settled copy for software reads when prescaler sync is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_shadow_reg <= 8'h00;
        end else if (!hw_limit_reg.prescaler_sync_enable || instr_phase_reg) begin
            count_shadow_reg <= count_value_reg;
        end
    end

    // Postscaler over period matches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_cnt_reg   <= 4'h0;
            postscaled_out <= 1'b0;
        end else if (!control_reg.run) begin
            post_cnt_reg   <= 4'h0;
            postscaled_out <= 1'b0;
        end else begin
            postscaled_out <= 1'b0;
            if (count_en && match) begin
                if (post_cnt_reg == control_reg.postscale_select) begin
                    post_cnt_reg   <= 4'h0;
                    postscaled_out <= 1'b1;
                end else begin
                    post_cnt_reg <= post_cnt_reg + 4'h1;
                end
            end
        end
    end

    // Selected external reset and mode to the mode logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_reset_active <= 1'b0;
            mode_out         <= 5'h00;
        end else begin
            if (ers_s2[ext_reset_select_reg] == ers_s3[ext_reset_select_reg]) begin
                ext_reset_active <= ers_s3[ext_reset_select_reg];
            end
            mode_out         <= hw_limit_reg.mode;
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    a_stop_holds_count: assert property (@(posedge pclk) disable iff (!presetn)
        !control_reg.run && !$past(control_reg.run) |-> $stable(count_value_reg))
        else $error("count moved while stopped");
    a_match_clears: assert property (@(posedge pclk) disable iff (!presetn)
        count_en && match |=> count_value_reg == 8'h00)
        else $error("match did not clear count");
    a_one_shot_run: assert property (@(posedge pclk) disable iff (!presetn)
        hw_clear_run && !wr_en |=> !control_reg.run)
        else $error("one-shot left run set");
    a_off_resets: assert property (@(posedge pclk) disable iff (!presetn)
        !control_reg.run |=> presc_cnt_reg == 7'h00 && post_cnt_reg == 4'h0)
        else $error("prescaler not held off");
    a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
        hw_limit_reg.run_bit_sync_enable && $rose(control_reg.run) |-> !run_eff [*2])
        else $error("run sync started early");
    a_sleep_halts: assert property (@(posedge pclk) disable iff (!presetn)
        hw_limit_reg.prescaler_sync_enable && sleep_mode |-> !tick)
        else $error("ticked in sleep");
    a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        $past(rd_en && !penable && paddr == HLTC_OFS_CLOCK_SELECT) |-> prdata[31:4] == 28'h0)
        else $error("upper bits not zero");
    a_presc_one: assert property (@(posedge pclk) disable iff (!presetn)
        control_reg.prescale_select == 3'h0 && control_reg.run |-> presc_tick == clk_edge)
        else $error("1:1 prescale broken");
    a_post_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        postscaled_out |-> $past(count_en && match))
        else $error("postscale pulse without match");
    a_prescaler_sync_enable_phase: assert property (@(posedge pclk) disable iff (!presetn)
        hw_limit_reg.prescaler_sync_enable && tick |-> instr_phase_reg)
        else $error("synced tick off instruction phase");

    c_one_shot: cover property (@(posedge pclk) disable iff (!presetn) hw_clear_run);
    c_post_out: cover property (@(posedge pclk) disable iff (!presetn) postscaled_out);
    c_sync_run: cover property (@(posedge pclk) disable iff (!presetn)
        hw_limit_reg.run_bit_sync_enable && state_reg == HLTC_ST_COUNT);
    c_pin_edge: cover property (@(posedge pclk) disable iff (!presetn)
        clk_edge && clock_select_reg == HLTC_CS_PIN);
    c_sleep_hold: cover property (@(posedge pclk) disable iff (!presetn)
        hw_limit_reg.prescaler_sync_enable && sleep_mode && control_reg.run);

endmodule

// [test/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hltc_pkg::*;

    logic                        pclk;
    logic                        presetn;
    logic                        psel;
    logic                        penable;
    logic                        pwrite;
    logic [11:0]                 paddr;
    logic [31:0]                 pwdata;
    logic [3:0]                  pstrb;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    logic [HLTC_NUM_SOURCES-1:0] clock_sources = '0;
    logic [15:0]                 ext_reset_sources;
    logic                        sleep_mode;
    logic                        ext_reset_active;
    logic                        postscaled_out;
    logic [4:0]                  mode_out;
    int                          errors;
    int                          comparisons;
    int                          pulses;
    int                          div_cnt = 0;
    logic [31:0]                 q_a;
    logic [31:0]                 q_b;

    hltc_timer dut (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .pstrb             (pstrb),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .clock_sources     (clock_sources),
        .ext_reset_sources (ext_reset_sources),
        .sleep_mode        (sleep_mode),
        .ext_reset_active  (ext_reset_active),
        .postscaled_out    (postscaled_out),
        .mode_out          (mode_out)
    );

    // ****************************************************************
    // Clock and pin clock
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Pin clock source toggles every 4 cycles
    always @(posedge pclk) begin
        div_cnt <= (div_cnt == 3) ? 0 : div_cnt + 1;
        if (div_cnt == 3) begin
            clock_sources[HLTC_CS_PIN] <= ~clock_sources[HLTC_CS_PIN];
        end
    end

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        rd(a, q);
        check(q, exp);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // Reset values of every register except the count
    task automatic chk_reset_vals();
        rd_chk(HLTC_OFS_CLOCK_SELECT, 32'h0);
        rd_chk(HLTC_OFS_CONTROL, 32'h0);
        rd_chk(HLTC_OFS_HW_LIMIT, 32'h0);
        rd_chk(HLTC_OFS_EXT_RESET, 32'h0);
        rd_chk(HLTC_OFS_PERIOD, {24'h0, HLTC_RST_PERIOD});
    endtask

    // Runs the timer from reset, so no leftover count above the period wraps
    task automatic rate(input logic [3:0] cs, input logic [7:0] hlt, input logic [7:0] per,
                        input logic [6:0] ctl, input int lo, input int hi);
        do_reset();
        wr(HLTC_OFS_CLOCK_SELECT, {28'h0, cs});
        wr(HLTC_OFS_HW_LIMIT, {24'h0, hlt});
        wr(HLTC_OFS_PERIOD, {24'h0, per});
        wr(HLTC_OFS_CONTROL, {24'h0, 1'b1, ctl});
        repeat (20) @(posedge pclk);
        pulses = 0;
        repeat (160) begin
            @(posedge pclk);
            if (postscaled_out === 1'b1) begin
                pulses++;
            end
        end
        check({31'h0, pulses >= lo && pulses <= hi}, 32'h1);
        wr(HLTC_OFS_CONTROL, 32'h0);
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        errors = 0;
        comparisons = 0;
        pulses = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        ext_reset_sources = 16'h0000;
        sleep_mode = 1'b0;
        do_reset();
        chk_reset_vals();
        // Unimplemented upper bits and field read back
        wr(HLTC_OFS_CLOCK_SELECT, 32'h0000_00ff);
        rd_chk(HLTC_OFS_CLOCK_SELECT, 32'h0000_000f);
        wr(HLTC_OFS_EXT_RESET, 32'h0000_00f3);
        rd_chk(HLTC_OFS_EXT_RESET, 32'h0000_0003);
        wr(HLTC_OFS_CONTROL, 32'h0000_007a);
        rd_chk(HLTC_OFS_CONTROL, 32'h0000_007a);
        wr(HLTC_OFS_HW_LIMIT, 32'h0000_0013);
        repeat (2) @(posedge pclk);
        check({27'h0, mode_out}, 32'h13);
        // Unmapped address answers with an error and reads zero
        apb(1'b0, 12'h0f0, 32'h0, q_a, q_b[0]);
        check({31'h0, q_b[0]}, 32'h1);
        check(q_a, 32'h0);
        // Selected external reset input reaches the output
        ext_reset_sources <= 16'h0008;
        repeat (6) @(posedge pclk);
        check({31'h0, ext_reset_active}, 32'h1);
        ext_reset_sources <= 16'h0000;
        // A second reset restores every register except the count
        do_reset();
        chk_reset_vals();
        // Period 3 on the system clock, postscale 1:2: a pulse per 8 cycles
        rate(HLTC_CS_SYSTEM, 8'h00, 8'h03, 7'h01, 19, 21);
        // Prescale 1:4, postscale 1:1: a pulse per 16 cycles
        rate(HLTC_CS_SYSTEM, 8'h00, 8'h03, 7'h20, 9, 11);
        // Pin clock of 8 cycles, period 1, either polarity, run sync on with the falling edge only
        rate(HLTC_CS_PIN, 8'h00, 8'h01, 7'h00, 9, 11);
        rate(HLTC_CS_PIN, 8'h60, 8'h01, 7'h00, 9, 11);
        // Stopping keeps the count value
        wr(HLTC_OFS_CLOCK_SELECT, {28'h0, HLTC_CS_SYSTEM});
        wr(HLTC_OFS_HW_LIMIT, 32'h0);
        wr(HLTC_OFS_PERIOD, 32'h0000_00ff);
        wr(HLTC_OFS_CONTROL, 32'h0000_0080);
        repeat (30) @(posedge pclk);
        wr(HLTC_OFS_CONTROL, 32'h0000_0000);
        rd(HLTC_OFS_COUNT, q_a);
        repeat (10) @(posedge pclk);
        rd_chk(HLTC_OFS_COUNT, q_a);
        // With prescaler sync the count holds during sleep
        wr(HLTC_OFS_HW_LIMIT, 32'h0000_0080);
        wr(HLTC_OFS_CONTROL, 32'h0000_0080);
        repeat (5) @(posedge pclk);
        sleep_mode <= 1'b1;
        repeat (5) @(posedge pclk);
        rd(HLTC_OFS_COUNT, q_a);
        repeat (20) @(posedge pclk);
        rd_chk(HLTC_OFS_COUNT, q_a);
        sleep_mode <= 1'b0;
        repeat (20) @(posedge pclk);
        rd(HLTC_OFS_COUNT, q_b);
        check({31'h0, q_b !== q_a}, 32'h1);
        wr(HLTC_OFS_CONTROL, 32'h0);
        // One-shot mode clears the run bit and the count at the match
        wr(HLTC_OFS_HW_LIMIT, {27'h0, HLTC_MODE_ONE_SHOT});
        wr(HLTC_OFS_PERIOD, 32'h0000_0005);
        wr(HLTC_OFS_CONTROL, 32'h0000_0083);
        repeat (300) @(posedge pclk);
        rd_chk(HLTC_OFS_CONTROL, 32'h0000_0003);
        rd_chk(HLTC_OFS_COUNT, 32'h0);
        test_done();
    end

    // Watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        test_done();
    end
endmodule
